// ---- pkg/codec_serial_params.svh ----
`ifndef CODEC_SERIAL_PARAMS_SVH
`define CODEC_SERIAL_PARAMS_SVH

// bits moved per data transfer interval
`define CODEC_WORD_BITS       16
// shift clocks per frame, small and large cascade
`define CODEC_FRAME_SMALL     256
`define CODEC_FRAME_LARGE     512
// master shift clock half period in mclk cycles, after reset
`define CODEC_HALF_DIV_RST    8'h02
`define CODEC_HALF_DIV_W      8
`define CODEC_FRAME_CNT_W     9

`endif

// ---- pkg/codec_serial_pkg.sv ----
package codec_serial_pkg;

  // pins toward the host serial port, as seen from the device
  typedef struct packed {
    logic master_slave_select;
    logic power_down_n;
    logic cascade_large;
    logic serial_shift_clock;
    logic frame_strobe;
    logic serial_in;
  } link_in_t;

  typedef struct packed {
    logic serial_shift_clock;
    logic serial_shift_clock_oe;
    logic frame_strobe;
    logic frame_strobe_oe;
    logic serial_out;
    logic serial_out_oe;
  } link_out_t;

  typedef enum logic [1:0] {
    MODE_POWER_DOWN,
    MODE_MASTER,
    MODE_SLAVE
  } port_mode_t;

endpackage : codec_serial_pkg

// ---- design/shift_word.sv ----
`timescale 1ns/100ps
module shift_word #(
  parameter int WIDTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             clear,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_data,
  input  wire logic             launch,
  input  wire logic             sample,
  input  wire logic             sample_bit,
  output logic                  out_bit,
  output logic [WIDTH-1:0]      in_word
);

  logic [WIDTH-1:0] tx_sh;

  // load puts the msb on the line at once, later launches walk down
  always_ff @(posedge mclk) begin
    if (clear) begin
      tx_sh   <= '0;
      out_bit <= 1'b0;
    end else if (load) begin
      out_bit <= load_data[WIDTH-1];
      tx_sh   <= {load_data[WIDTH-2:0], 1'b0};
    end else if (launch) begin
      out_bit <= tx_sh[WIDTH-1];
      tx_sh   <= {tx_sh[WIDTH-2:0], 1'b0};
    end
  end

  always_ff @(posedge mclk) begin
    if (clear) begin
      in_word <= '0;
    end else if (sample) begin
      in_word <= {in_word[WIDTH-2:0], sample_bit};
    end
  end

endmodule : shift_word

// ---- design/codec_serial_clock_power_ctrl.sv ----
`timescale 1ns/100ps
`include "codec_serial_params.svh"
// Functional notes
// - master_slave_select high makes the port master, low makes it slave.
// - power_down_n low disables the serial port and stops the fast clocks.
// - configuration registers survive power-down; operation resumes with no reprogramming.
// - power-down clears the counters and the shift registers, never the configuration.
// - reset loads every configuration register with its default value.
// - master drives shift clock at 256 or 512 times the frame rate.
// - data shifts on serial_in and serial_out only inside the frame interval.
// - all internal clocking derives from the master clock input.
// - master generates frame_strobe low during transfer; slave takes host's.
// - serial_in sampled on falling shift clock while frame_strobe is low.
// - serial_out launched on rising edge while strobe low, else released.
// - primary frames repeat every 256 or 512 shift clocks.
module codec_serial_clock_power_ctrl
  import codec_serial_pkg::*;
#(
  parameter int WORD_BITS = `CODEC_WORD_BITS
) (
  input  wire logic                         mclk,
  input  wire logic                         sys_rst,
  input  wire link_in_t                     link_in,
  output link_out_t                         link_out,
  input  wire logic                         cfg_we,
  input  wire logic [`CODEC_HALF_DIV_W-1:0] cfg_half_div,
  output logic [`CODEC_HALF_DIV_W-1:0]      half_div,
  input  wire logic [WORD_BITS-1:0]         tx_word,
  output logic                              tx_taken,
  output logic [WORD_BITS-1:0]              rx_word,
  output logic                              rx_valid,
  output port_mode_t                        mode
);

  localparam int BW = $clog2(WORD_BITS + 1);
  localparam logic [`CODEC_FRAME_CNT_W-1:0] LAST_SMALL =
    `CODEC_FRAME_CNT_W'(`CODEC_FRAME_SMALL - 1);
  localparam logic [`CODEC_FRAME_CNT_W-1:0] LAST_LARGE =
    `CODEC_FRAME_CNT_W'(`CODEC_FRAME_LARGE - 1);
  localparam logic [`CODEC_FRAME_CNT_W-1:0] XFER_END =
    `CODEC_FRAME_CNT_W'(WORD_BITS);

  link_in_t                         sync1;
  link_in_t                         sync2;
  logic                             sclk_prev;
  logic [`CODEC_HALF_DIV_W-1:0]     div_cnt;
  logic                             sclk_gen;
  logic [`CODEC_FRAME_CNT_W-1:0]    frame_cnt;
  logic [BW-1:0]                    bit_cnt;
  logic [WORD_BITS-1:0]             in_word;
  logic                             out_bit;
  logic                             running;
  logic                             div_wrap;
  logic                             rise_ev;
  logic                             fall_ev;
  logic                             fs_low;
  logic                             in_xfer;
  logic                             launch;
  logic                             sample;
  logic                             load;
  logic [`CODEC_FRAME_CNT_W-1:0]    frame_last;

  // two flops on every pin before any logic looks at it
  always_ff @(posedge mclk) begin
    sync1 <= link_in;
    sync2 <= sync1;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode <= MODE_POWER_DOWN;
    end else begin
      case ({sync2.power_down_n, sync2.master_slave_select})
        2'b11:   mode <= MODE_MASTER;
        2'b10:   mode <= MODE_SLAVE;
        default: mode <= MODE_POWER_DOWN;
      endcase
    end
  end

  assign running = (mode != MODE_POWER_DOWN);

  // configuration is touched by reset and writes only, never by power-down
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      half_div <= `CODEC_HALF_DIV_RST;
    end else if (cfg_we) begin
      half_div <= (cfg_half_div == '0) ? 8'h01 : cfg_half_div;
    end
  end

  // master shift clock divided down from mclk
  // >= so that a smaller divider written mid-run cannot stall the clock
  assign div_wrap = (mode == MODE_MASTER) && (div_cnt >= half_div - 8'h01);

  always_ff @(posedge mclk) begin
    if (sys_rst || mode != MODE_MASTER) begin
      div_cnt  <= '0;
      sclk_gen <= 1'b0;
    end else if (div_wrap) begin
      div_cnt  <= '0;
      sclk_gen <= ~sclk_gen;
    end else begin
      div_cnt  <= div_cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    sclk_prev <= sync2.serial_shift_clock;
  end

  always_comb begin
    rise_ev = 1'b0;
    fall_ev = 1'b0;
    fs_low  = 1'b0;
    case (mode)
      MODE_MASTER: begin
        rise_ev = div_wrap && !sclk_gen;
        fall_ev = div_wrap && sclk_gen;
        fs_low  = (frame_cnt < XFER_END);
      end
      MODE_SLAVE: begin
        rise_ev = sync2.serial_shift_clock && !sclk_prev;
        fall_ev = !sync2.serial_shift_clock && sclk_prev;
        fs_low  = !sync2.frame_strobe;
      end
      default: begin
        rise_ev = 1'b0;
        fall_ev = 1'b0;
        fs_low  = 1'b0;
      end
    endcase
  end

  assign frame_last = sync2.cascade_large ? LAST_LARGE : LAST_SMALL;

  // shift clocks counted per frame; the strobe falls when this wraps
  always_ff @(posedge mclk) begin
    if (sys_rst || mode != MODE_MASTER) begin
      frame_cnt <= '0;
    end else if (fall_ev) begin
      if (frame_cnt >= frame_last) begin
        frame_cnt <= '0;
      end else begin
        frame_cnt <= frame_cnt + 9'h001;
      end
    end
  end

  assign in_xfer = fs_low && (bit_cnt < BW'(WORD_BITS));
  assign load    = rise_ev && in_xfer && (bit_cnt == '0);
  assign launch  = rise_ev && in_xfer && (bit_cnt != '0);
  assign sample  = fall_ev && in_xfer;

  always_ff @(posedge mclk) begin
    if (sys_rst || !running || !fs_low) begin
      bit_cnt <= '0;
    end else if (sample) begin
      bit_cnt <= bit_cnt + BW'(1);
    end
  end

  shift_word #(
    .WIDTH      (WORD_BITS)
  ) u_shift (
    .mclk       (mclk),
    .clear      (sys_rst || !running),
    .load       (load),
    .load_data  (tx_word),
    .launch     (launch),
    .sample     (sample),
    .sample_bit (sync2.serial_in),
    .out_bit    (out_bit),
    .in_word    (in_word)
  );

  assign tx_taken = load;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= sample && (bit_cnt == BW'(WORD_BITS - 1));
    end
  end

  assign rx_word = in_word;

  always_comb begin
    link_out.serial_shift_clock    = sclk_gen;
    link_out.serial_shift_clock_oe = (mode == MODE_MASTER);
    link_out.frame_strobe          = !fs_low;
    link_out.frame_strobe_oe       = (mode == MODE_MASTER);
    link_out.serial_out            = out_bit;
    link_out.serial_out_oe         = running && fs_low;
  end

  sequence launch_s;
    rise_ev && in_xfer;
  endsequence

  sequence sample_s;
    fall_ev && fs_low;
  endsequence

  property launch_then_sample_p;
    @(posedge mclk) disable iff (sys_rst)
      (mode == MODE_MASTER) ##0 launch_s |-> ##[1:600] sample_s;
  endproperty

  role_select_a: assert property (@(posedge mclk) disable iff (sys_rst)
    sync2.power_down_n && sync2.master_slave_select |=>
      link_out.serial_shift_clock_oe && link_out.frame_strobe_oe)
    else $error("master select did not drive the clocks");

  power_down_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !sync2.power_down_n |=> !link_out.serial_out_oe
      && !link_out.serial_shift_clock_oe && !link_out.frame_strobe_oe)
    else $error("port still active in power-down");

  config_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !cfg_we |=> $stable(half_div))
    else $error("configuration changed without a write");

  counter_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    mode == MODE_POWER_DOWN |=> frame_cnt == '0 && bit_cnt == '0
      && div_cnt == '0)
    else $error("counters running in power-down");

  reset_default_a: assert property (@(posedge mclk)
    sys_rst |=> half_div == `CODEC_HALF_DIV_RST && mode == MODE_POWER_DOWN)
    else $error("reset did not restore defaults");

  frame_wrap_a: assert property (@(posedge mclk) disable iff (sys_rst)
    mode == MODE_MASTER && fall_ev && frame_cnt == frame_last
      |=> frame_cnt == '0 && !link_out.frame_strobe)
    else $error("frame length wrong");

  sclk_period_a: assert property (@(posedge mclk) disable iff (sys_rst)
    mode == MODE_MASTER && !div_wrap
      |=> $stable(link_out.serial_shift_clock))
    else $error("shift clock toggled early");

  sample_window_a: assert property (@(posedge mclk) disable iff (sys_rst)
    sample |-> fs_low && fall_ev && bit_cnt < BW'(WORD_BITS))
    else $error("serial_in sampled outside the frame");

  out_release_a: assert property (@(posedge mclk) disable iff (sys_rst)
    link_out.serial_out_oe |-> fs_low && running)
    else $error("serial_out driven outside the frame");

  master_fs_a: assert property (@(posedge mclk) disable iff (sys_rst)
    mode == MODE_MASTER |-> link_out.frame_strobe == (frame_cnt >= XFER_END))
    else $error("master strobe not low for the transfer");

  shift_pair_a: assert property (launch_then_sample_p)
    else $error("launched bit never sampled");

endmodule : codec_serial_clock_power_ctrl

// ---- tb/host_port_model.sv ----
`timescale 1ns/100ps
module host_port_model
  import codec_serial_pkg::*;
(
  input  wire link_out_t   dev_out,
  input  wire logic [15:0] send_word,
  output logic             clk_w,
  output logic             fs_w,
  output logic             sdi,
  output logic [15:0]      got
);
  logic        sclk = 1'b0;
  logic        fs   = 1'b1;
  logic        fs_q = 1'b1;
  logic [15:0] tx_sh;
  logic        so_d;

  // line level just before each edge, as a latch with hold time sees it
  assign #1 so_d = dev_out.serial_out_oe ? dev_out.serial_out : 1'bz;

  initial sdi = 1'b0;
  // wire level from whichever party enables its driver
  assign clk_w = dev_out.serial_shift_clock_oe ? dev_out.serial_shift_clock
                                               : sclk;
  assign fs_w = dev_out.frame_strobe_oe ? dev_out.frame_strobe : fs;

  always @(posedge clk_w) begin
    if (!fs_w && fs_q) begin
      sdi <= send_word[15];
      tx_sh <= send_word << 1;
    end else if (!fs_w) begin
      sdi <= tx_sh[15];
      tx_sh <= tx_sh << 1;
    end
    fs_q <= fs_w;
  end

  // released data line flips so a stale value cannot pass
  always @(posedge fs_w) begin
    fs_q <= 1'b1;
    sdi <= ~sdi;
  end

  // a released output line reads as z and fails the compare
  always @(negedge clk_w) begin
    if (!fs_q) begin
      got <= {got[14:0], so_d};
    end
  end

  // one slave-role frame; clock stands still outside it
  task automatic frame;
    #3.3 fs = 1'b0;
    #62.5;
    repeat (16) begin
      sclk = 1'b1;
      #62.5 sclk = 1'b0;
      #62.5;
    end
    fs = 1'b1;
  endtask : frame
endmodule : host_port_model

// ---- tb/tb_codec_serial_clock_power_ctrl.sv ----
`timescale 1ns/100ps
module tb_codec_serial_clock_power_ctrl
  import codec_serial_pkg::*;
;
  logic        mclk, sys_rst, cfg_we, mss, pdn, casc;
  logic        tx_taken, rx_valid, clk_w, fs_w, sdi;
  logic [7:0]  cfg_half_div, half_div, lfsr;
  logic [15:0] tx_word, host_word, rx_word, got;
  link_in_t    link_in;
  link_out_t   link_out;
  port_mode_t  mode;
  int          n_errors = 0, comparisons = 0, cycles = 0, n_rxv = 0;
  int          nclk, nfall, rx0, tx0;
  int          n_txt = 0;

  assign link_in = {mss, pdn, casc, clk_w, fs_w, sdi};

  codec_serial_clock_power_ctrl DUT (.mclk(mclk), .sys_rst(sys_rst),
    .link_in(link_in), .link_out(link_out), .cfg_we(cfg_we),
    .cfg_half_div(cfg_half_div), .half_div(half_div), .tx_word(tx_word),
    .tx_taken(tx_taken), .rx_word(rx_word), .rx_valid(rx_valid),
    .mode(mode));
  host_port_model host (.dev_out(link_out), .send_word(host_word),
    .clk_w(clk_w), .fs_w(fs_w), .sdi(sdi), .got(got));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [7:0] lfsr_step(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_step

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  always @(posedge mclk) begin
    cycles++;
    if (rx_valid === 1'b1) n_rxv++;
    if (tx_taken === 1'b1) n_txt++;
    if (cycles == 40000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic wait_lvl(logic lvl);
    int k;
    k = 0;
    while (fs_w !== lvl && k < 9000) begin
      tick(1);
      k++;
    end
    if (k == 9000) check("strobe wait", 0, 1);
  endtask : wait_lvl

  // mclk cycles and shift clock falls between two strobe falls
  task automatic frame_len;
    logic p, lvl;
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    nclk = 0;
    nfall = 0;
    p = clk_w;
    lvl = 1'b1;
    repeat (2) begin
      while (fs_w !== lvl && nclk < 9000) begin
        tick(1);
        nclk++;
        nfall += int'(p && !clk_w);
        p = clk_w;
      end
      lvl = 1'b0;
    end
  endtask : frame_len

  task automatic new_words;
    lfsr = lfsr_step(lfsr);
    tx_word = {lfsr, ~lfsr};
    lfsr = lfsr_step(lfsr);
    host_word = {lfsr_step(lfsr), lfsr};
  endtask : new_words

  task automatic data_check;
    check("rx word", rx_word, host_word);
    check("host word", got, tx_word);
    check("rx count", n_rxv - rx0, 1);
    check("tx count", n_txt - tx0, 1);
  endtask : data_check

  task automatic master_frame(int hd, int len);
    frame_len();
    check("frame mclk", nclk, 2 * len * hd);
    check("frame falls", nfall, len);
    rx0 = n_rxv;
    tx0 = n_txt;
    wait_lvl(1'b1);
    tick(4);
    data_check();
  endtask : master_frame

  initial begin
    sys_rst = 1'b1;
    cfg_we = 1'b0;
    cfg_half_div = 8'h00;
    mss = 1'b0;
    pdn = 1'b0;
    casc = 1'b0;
    lfsr = 8'h33;
    new_words();
    tick(5);
    check("mode", mode, MODE_POWER_DOWN);
    check("half_div", half_div, 8'h02);
    sys_rst = 1'b0;
    for (int i = 0; i < 5; i++) begin
      lfsr = lfsr_step(lfsr);
      cfg_half_div = (i == 0) ? 8'h00 : (i == 4) ? 8'h04 : lfsr;
      cfg_we = 1'b1;
      tick(1);
      cfg_we = 1'b0;
      check("half_div", half_div, (i == 0) ? 8'h01 : cfg_half_div);
    end
    $display("test config done");
    mss = 1'b1;
    pdn = 1'b1;
    for (int c = 0; c < 2; c++) begin
      casc = c[0];
      new_words();
      frame_len();
      check("mode", mode, MODE_MASTER);
      master_frame(4, c ? 512 : 256);
    end
    $display("test master done");
    wait_lvl(1'b1);
    tick(30);
    pdn = 1'b0;
    tick(4);
    check("mode", mode, MODE_POWER_DOWN);
    check("oe", {link_out.serial_shift_clock_oe, link_out.frame_strobe_oe,
      link_out.serial_out_oe}, 0);
    check("half_div", half_div, 8'h04);
    pdn = 1'b1;
    new_words();
    master_frame(4, 512);
    $display("test power down done");
    mss = 1'b0;
    tick(4);
    check("mode", mode, MODE_SLAVE);
    repeat (3) begin
      new_words();
      rx0 = n_rxv;
      tx0 = n_txt;
      host.frame();
      tick(4);
      data_check();
    end
    $display("test slave done");
    close_out();
  end
endmodule : tb_codec_serial_clock_power_ctrl
